/* logic/cgl_line_control.sv */
// Four-line general purpose I/O control with filters and output source select
`timescale 1ns/1ps

module cgl_line_control
    import cgl_pkg::*;
#(
    parameter int NUM_LINES = 4,
    parameter int SPAN_W    = 16,
    parameter logic [7:0] CIRCUIT_TYPES = {CGL_FMT_TRISTATE, CGL_FMT_TRISTATE, CGL_FMT_OPENDRAIN, CGL_FMT_OPTO}
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic [3:0]           regAddr,
    input  wire logic [31:0]          regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [31:0]          regRdata,
    input  wire logic [NUM_LINES-1:0] linePinIn,
    output logic      [NUM_LINES-1:0] linePinOut,
    output logic      [NUM_LINES-1:0] linePinOe,
    input  wire logic                 counterActive,
    input  wire logic                 logicBlockOut,
    input  wire logic                 sensorExposing,
    input  wire logic                 frameTriggerArmed
);

    logic [1:0]           lineSel_r;
    logic [NUM_LINES-1:0] direction_r;
    logic [NUM_LINES-1:0] invert_r;
    logic                 fltKind_r;
    logic [SPAN_W-1:0]    glitchSpan_r [NUM_LINES];
    logic [SPAN_W-1:0]    bounceSpan_r [NUM_LINES];
    logic [3:0]           source_r [NUM_LINES];
    logic [1:0]           softIdx_r;
    logic [NUM_LINES-1:0] softOut_r;
    logic [NUM_LINES-1:0] level;
    logic [NUM_LINES-1:0] drive;
    logic [6:0]           tickCnt_r;
    logic                 usTick;

    // Write decode shorthand
    function automatic logic wrHit(input logic [3:0] a);
        return regWrite && (regAddr == a);
    endfunction : wrHit

    // Microsecond tick for the filter timers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_r <= 7'h00;
        end else if (usTick) begin
            tickCnt_r <= 7'h00;
        end else begin
            tickCnt_r <= tickCnt_r + 7'h01;
        end
    end
    assign usTick = (tickCnt_r == 7'(CGL_TICK_CYCLES - 1));

    // Global selectors
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lineSel_r <= 2'h0;
            fltKind_r <= 1'b0;
            softIdx_r <= 2'h0;
        end else begin
            if (wrHit(CGL_REG_LINE_SEL)) begin
                lineSel_r <= regWdata[1:0];
            end
            if (wrHit(CGL_REG_FILTER_KIND)) begin
                fltKind_r <= regWdata[0];
            end
            if (wrHit(CGL_REG_SOFT_IDX)) begin
                softIdx_r <= regWdata[1:0];
            end
        end
    end

    // Soft output bits, single or whole vector
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            softOut_r <= '0;
        end else if (wrHit(CGL_REG_SOFT_ALL)) begin
            softOut_r <= regWdata[NUM_LINES-1:0];
        end else if (wrHit(CGL_REG_SOFT_LEVEL)) begin
            softOut_r[softIdx_r] <= regWdata[0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : gLine
            logic       sync1_r;
            logic       sync2_r;
            logic       glitchOut_r;
            logic       bounceOut_r;
            logic [SPAN_W-1:0] glitchCnt_r;
            logic [SPAN_W-1:0] bounceCnt_r;
            logic       polIn;
            logic       srcSel;

            // Per-line configuration
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    direction_r[g]  <= 1'b0;
                    invert_r[g]     <= 1'b0;
                    glitchSpan_r[g] <= CGL_SPAN_RST;
                    bounceSpan_r[g] <= CGL_SPAN_RST;
                    source_r[g]     <= CGL_SOURCE_RST;
                end else if (regWrite && lineSel_r == 2'(g)) begin
                    if (regAddr == CGL_REG_DIRECTION) begin
                        direction_r[g] <= regWdata[0];
                    end else if (regAddr == CGL_REG_INVERT) begin
                        invert_r[g] <= regWdata[0];
                    end else if (regAddr == CGL_REG_FILTER_SPAN && fltKind_r == CGL_FLT_DEGLITCH) begin
                        glitchSpan_r[g] <= regWdata[SPAN_W-1:0];
                    end else if (regAddr == CGL_REG_FILTER_SPAN) begin
                        bounceSpan_r[g] <= regWdata[SPAN_W-1:0];
                    end else if (regAddr == CGL_REG_SOURCE) begin
                        source_r[g] <= regWdata[3:0];
                    end
                end
            end

            // Two-stage synchroniser
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    sync1_r <= 1'b0;
                    sync2_r <= 1'b0;
                end else begin
                    sync1_r <= linePinIn[g];
                    sync2_r <= sync1_r;
                end
            end
            assign polIn = sync2_r ^ invert_r[g];

            // Deglitch: new level must persist a full width
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    glitchOut_r <= 1'b0;
                    glitchCnt_r <= '0;
                end else if (polIn == glitchOut_r) begin
                    glitchCnt_r <= '0;
                end else if (glitchCnt_r >= glitchSpan_r[g]) begin
                    glitchOut_r <= polIn;
                    glitchCnt_r <= '0;
                end else if (usTick) begin
                    glitchCnt_r <= glitchCnt_r + SPAN_W'(1);
                end
            end

            // Debounce: first edge passes, then a lockout of the width
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    bounceOut_r <= 1'b0;
                    bounceCnt_r <= '0;
                end else if (bounceCnt_r != '0) begin
                    if (usTick) begin
                        bounceCnt_r <= bounceCnt_r - SPAN_W'(1);
                    end
                end else if (glitchOut_r != bounceOut_r) begin
                    bounceOut_r <= glitchOut_r;
                    bounceCnt_r <= bounceSpan_r[g];
                end
            end

            // Output source mux
            always_comb begin
                if (source_r[g] <= CGL_SRC_LINE3) begin
                    srcSel = level[source_r[g][1:0]];
                end else if (source_r[g] <= CGL_SRC_SOFT3) begin
                    srcSel = softOut_r[source_r[g][1:0]];
                end else if (source_r[g] == CGL_SRC_COUNTER) begin
                    srcSel = counterActive;
                end else if (source_r[g] == CGL_SRC_LOGIC) begin
                    srcSel = logicBlockOut;
                end else if (source_r[g] == CGL_SRC_EXPOSING) begin
                    srcSel = sensorExposing;
                end else if (source_r[g] == CGL_SRC_ARMED) begin
                    srcSel = frameTriggerArmed;
                end else begin
                    srcSel = 1'b0;
                end
            end

            // Registered pin drive; level shows driven or filtered value
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    drive[g] <= 1'b0;
                end else begin
                    drive[g] <= srcSel ^ invert_r[g];
                end
            end
            assign linePinOut[g] = drive[g];
            assign linePinOe[g]  = (direction_r[g] == CGL_DIR_OUT);
            assign level[g] = linePinOe[g] ? (drive[g] ^ invert_r[g]) : bounceOut_r;
        end
    endgenerate

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 32'h0000_0000;
        end else if (!regRead) begin
            regRdata <= 32'h0000_0000;
        end else if (regAddr == CGL_REG_LINE_SEL) begin
            regRdata <= {30'h0, lineSel_r};
        end else if (regAddr == CGL_REG_DIRECTION) begin
            regRdata <= {31'h0, direction_r[lineSel_r]};
        end else if (regAddr == CGL_REG_INVERT) begin
            regRdata <= {31'h0, invert_r[lineSel_r]};
        end else if (regAddr == CGL_REG_LEVEL) begin
            regRdata <= {31'h0, level[lineSel_r]};
        end else if (regAddr == CGL_REG_LEVEL_ALL) begin
            regRdata <= {28'h0, level};
        end else if (regAddr == CGL_REG_FILTER_KIND) begin
            regRdata <= {31'h0, fltKind_r};
        end else if (regAddr == CGL_REG_FILTER_SPAN) begin
            regRdata <= {16'h0, fltKind_r ? bounceSpan_r[lineSel_r] : glitchSpan_r[lineSel_r]};
        end else if (regAddr == CGL_REG_SOURCE) begin
            regRdata <= {28'h0, source_r[lineSel_r]};
        end else if (regAddr == CGL_REG_SOFT_IDX) begin
            regRdata <= {30'h0, softIdx_r};
        end else if (regAddr == CGL_REG_SOFT_LEVEL) begin
            regRdata <= {31'h0, softOut_r[softIdx_r]};
        end else if (regAddr == CGL_REG_SOFT_ALL) begin
            regRdata <= {28'h0, softOut_r};
        end else if (regAddr == CGL_REG_CIRCUIT) begin
            regRdata <= {30'h0, CIRCUIT_TYPES[lineSel_r*2 +: 2]};
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // Direction write on line 1 reaches its output enable next cycle
    dir_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regWrite && regAddr == CGL_REG_DIRECTION && lineSel_r == 2'h1 |=> linePinOe[1] == $past(regWdata[0]))
        else $error("direction write not seen on output enable");

    // Output enables move only on a direction write
    oe_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(regWrite && regAddr == CGL_REG_DIRECTION) |=> $stable(linePinOe))
        else $error("output enable moved without a write");

    // Level vector read returns levels sampled at the strobe
    level_all_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regRead && regAddr == CGL_REG_LEVEL_ALL |=> regRdata == {28'h0, $past(level)})
        else $error("level vector read mismatch");

    // Selected line readback returns that line's level
    level_sel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regRead && regAddr == CGL_REG_LEVEL |=> regRdata == {31'h0, $past(level[lineSel_r])})
        else $error("selected level read mismatch");

    // Soft vector write lands in the soft outputs next cycle
    soft_all_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regWrite && regAddr == CGL_REG_SOFT_ALL |=> softOut_r == $past(regWdata[3:0]))
        else $error("soft vector write lost");

    // Single soft write touches the indexed bit
    soft_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regWrite && regAddr == CGL_REG_SOFT_LEVEL |=> softOut_r[$past(softIdx_r)] == $past(regWdata[0]))
        else $error("soft bit write lost");

    // Soft outputs hold unless one of their two places is written
    soft_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        !(regWrite && (regAddr == CGL_REG_SOFT_LEVEL || regAddr == CGL_REG_SOFT_ALL)) |=> $stable(softOut_r))
        else $error("soft outputs moved without a write");

    // Tick period exact
    us_tick_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        usTick |=> !usTick ##123 !usTick ##1 usTick) else $error("tick period wrong");

    // Tick counter never passes its wrap point
    tick_range_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        tickCnt_r <= 7'(CGL_TICK_CYCLES - 1))
        else $error("tick counter out of range");

    // Loopback of line 0 onto line 1
    loop_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        source_r[1] == CGL_SRC_LINE0 && !invert_r[1] |=> linePinOut[1] == $past(level[0]))
        else $error("loopback not driven");

    // Counter-active source on line 1
    counter_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        source_r[1] == CGL_SRC_COUNTER && !invert_r[1] |=> linePinOut[1] == $past(counterActive))
        else $error("counter flag not driven");

    // Logic-block source on line 1
    logic_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        source_r[1] == CGL_SRC_LOGIC && !invert_r[1] |=> linePinOut[1] == $past(logicBlockOut))
        else $error("logic block output not driven");

    // Exposing source on line 1
    expose_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        source_r[1] == CGL_SRC_EXPOSING && !invert_r[1] |=> linePinOut[1] == $past(sensorExposing))
        else $error("exposing flag not driven");

    // Armed source routed with inversion off
    armed_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        source_r[1] == CGL_SRC_ARMED && !invert_r[1] |=> linePinOut[1] == $past(frameTriggerArmed))
        else $error("armed flag not driven");

    // Inversion on line 1 output, taken with the source one cycle back
    invert_out_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        source_r[1] == CGL_SRC_SOFT0 |=> linePinOut[1] == ($past(softOut_r[0]) ^ $past(invert_r[1])))
        else $error("output inversion wrong");

    // Second synchroniser stage carries the pin two cycles late
    sync_path_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        gLine[0].sync2_r == $past(linePinIn[0], 2))
        else $error("synchroniser delay wrong");

    // Deglitch moves only to the held input once the width has run out
    deglitch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(gLine[2].glitchOut_r) |-> gLine[2].glitchOut_r == $past(gLine[2].polIn) &&
            $past(gLine[2].glitchCnt_r) >= $past(glitchSpan_r[2]))
        else $error("deglitch output not from held input");

    // Deglitch output holds while the input agrees with it
    glitch_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        gLine[2].polIn == gLine[2].glitchOut_r |=> $stable(gLine[2].glitchOut_r))
        else $error("deglitch output moved without cause");

    // Debounce moves only when lockout is clear
    debounce_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(gLine[3].bounceOut_r) |-> $past(gLine[3].bounceCnt_r) == '0)
        else $error("debounce changed during lockout");

    // A passed edge loads the full lockout width
    bounce_lock_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        $changed(gLine[3].bounceOut_r) |-> gLine[3].bounceCnt_r == $past(bounceSpan_r[3]))
        else $error("debounce lockout not loaded");

    // Circuit type read gives a defined code only
    circuit_ro_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        regRead && regAddr == CGL_REG_CIRCUIT |=> regRdata[31:2] == 30'h0 && regRdata[1:0] != 2'h3)
        else $error("circuit type code undefined");

endmodule : cgl_line_control

/* logic/cgl_pkg.sv */
// Package for the camera I/O line control block: register map, fields, timing
package cgl_pkg;

    // Register addresses (word index on the plain register port)
    localparam logic [3:0] CGL_REG_LINE_SEL     = 4'h0;
    localparam logic [3:0] CGL_REG_DIRECTION    = 4'h1;
    localparam logic [3:0] CGL_REG_INVERT       = 4'h2;
    localparam logic [3:0] CGL_REG_LEVEL        = 4'h3;
    localparam logic [3:0] CGL_REG_LEVEL_ALL    = 4'h4;
    localparam logic [3:0] CGL_REG_FILTER_KIND  = 4'h5;
    localparam logic [3:0] CGL_REG_FILTER_SPAN  = 4'h6;
    localparam logic [3:0] CGL_REG_SOURCE       = 4'h7;
    localparam logic [3:0] CGL_REG_SOFT_IDX     = 4'h8;
    localparam logic [3:0] CGL_REG_SOFT_LEVEL   = 4'h9;
    localparam logic [3:0] CGL_REG_SOFT_ALL     = 4'ha;
    localparam logic [3:0] CGL_REG_CIRCUIT      = 4'hb;

    // Reset values
    localparam logic [15:0] CGL_SPAN_RST    = 16'h0000;
    localparam logic [3:0]  CGL_SOURCE_RST  = 4'h0;

    // Timing: one microsecond tick from the 125 MHz clock
    localparam int CGL_CLK_MHZ     = 125;
    localparam int CGL_TICK_US     = 1;
    localparam int CGL_TICK_CYCLES = CGL_CLK_MHZ * CGL_TICK_US;

    // Direction of a line
    typedef enum logic {CGL_DIR_IN, CGL_DIR_OUT} cgl_dir_t;

    // Filter kind selector
    typedef enum logic {CGL_FLT_DEGLITCH, CGL_FLT_DEBOUNCE} cgl_flt_t;

    // Output source choices; loopback codes select line 0..3
    localparam logic [3:0] CGL_SRC_LINE0    = 4'h0;
    localparam logic [3:0] CGL_SRC_LINE3    = 4'h3;
    localparam logic [3:0] CGL_SRC_SOFT0    = 4'h4;
    localparam logic [3:0] CGL_SRC_SOFT3    = 4'h7;
    localparam logic [3:0] CGL_SRC_COUNTER  = 4'h8;
    localparam logic [3:0] CGL_SRC_LOGIC    = 4'h9;
    localparam logic [3:0] CGL_SRC_EXPOSING = 4'ha;
    localparam logic [3:0] CGL_SRC_ARMED    = 4'hb;

    // Circuit type codes
    localparam logic [1:0] CGL_FMT_TRISTATE  = 2'h0;
    localparam logic [1:0] CGL_FMT_OPTO      = 2'h1;
    localparam logic [1:0] CGL_FMT_OPENDRAIN = 2'h2;

endpackage : cgl_pkg

/* sim/cgl_ext_circuit.sv */
// External circuits wired to the four connector lines
`timescale 1ns/1ps
module cgl_ext_circuit
    import cgl_pkg::*;
#(
    parameter int NUM_LINES = 4
) (
    input  wire logic [NUM_LINES-1:0] extDrive,
    input  wire logic [NUM_LINES-1:0] linePinOut,
    input  wire logic [NUM_LINES-1:0] linePinOe,
    output logic      [NUM_LINES-1:0] linePinLevel
);
    // Device drives the pin when enabled, else the circuit sets it
    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            linePinLevel[i] = linePinOe[i] ? linePinOut[i] : extDrive[i];
        end
    end
endmodule : cgl_ext_circuit

/* sim/cgl_line_control_bench.sv */
// Self-checking bench for the camera I/O line control block
`timescale 1ns/1ps
module cgl_line_control_bench
    import cgl_pkg::*;
;
    logic        ref_clk  = 1'b0;
    logic        rstn     = 1'b0;
    logic [3:0]  regAddr  = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead  = 1'b0;
    logic [31:0] regRdata;
    logic [3:0]  linePinLevel;
    logic [3:0]  linePinOut;
    logic [3:0]  linePinOe;
    logic [3:0]  extDrive = 4'h0;
    logic [3:0]  srcIn    = 4'h0; // Counter, logic block, exposing, armed
    int          n_fail   = 0;
    int          n_checks = 0;
    int          cycles   = 0;

    always #4 ref_clk = ~ref_clk;

    cgl_line_control i_dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .linePinIn(linePinLevel),
        .linePinOut(linePinOut), .linePinOe(linePinOe), .counterActive(srcIn[0]),
        .logicBlockOut(srcIn[1]), .sensorExposing(srcIn[2]), .frameTriggerArmed(srcIn[3]));

    cgl_ext_circuit i_ext (.extDrive(extDrive), .linePinOut(linePinOut), .linePinOe(linePinOe),
        .linePinLevel(linePinLevel));

    // Verdict and end of run
    task automatic print_verdict();
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkReg

    task automatic chkPin(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask : chkPin

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr

    // Read and compare; data stands in the cycle after the strobe
    task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        chkReg(regRdata, exp);
    endtask : rdChk

    task automatic setFilter(input logic [1:0] ln, input logic k, input logic [15:0] us);
        wr(CGL_REG_LINE_SEL, {30'h0, ln});
        wr(CGL_REG_FILTER_KIND, {31'h0, k});
        wr(CGL_REG_FILTER_SPAN, {16'h0, us});
    endtask : setFilter

    // Reset values, circuit codes, read-only and unmapped places
    task automatic t_reset_types();
        logic [1:0] fmt;
        for (int i = 0; i < 4; i++) begin
            fmt = (i == 0) ? CGL_FMT_OPTO : (i == 1) ? CGL_FMT_OPENDRAIN : CGL_FMT_TRISTATE;
            wr(CGL_REG_LINE_SEL, 32'(i));
            wr(CGL_REG_CIRCUIT, 32'h3);
            rdChk(CGL_REG_CIRCUIT, {30'h0, fmt});
            rdChk(CGL_REG_DIRECTION, 32'h0);
            rdChk(CGL_REG_FILTER_SPAN, 32'h0);
        end
        wr(4'hc, 32'h5);
        rdChk(4'hc, 32'h0);
        chkPin(linePinOe, 4'h0);
    endtask : t_reset_types

    // Input levels, per-line readback, vector and inversion
    task automatic t_input_levels();
        extDrive <= 4'h5;
        cyc(10);
        rdChk(CGL_REG_LEVEL_ALL, 32'h5);
        for (int i = 0; i < 4; i++) begin
            wr(CGL_REG_LINE_SEL, 32'(i));
            rdChk(CGL_REG_LEVEL, {31'h0, ~i[0]});
        end
        wr(CGL_REG_LINE_SEL, 32'h0);
        wr(CGL_REG_INVERT, 32'h1);
        cyc(10);
        rdChk(CGL_REG_LEVEL_ALL, 32'h4);
        wr(CGL_REG_INVERT, 32'h0);
    endtask : t_input_levels

    // Soft outputs and every output source on line 1 except its own loopback
    task automatic t_sources();
        logic e;
        wr(CGL_REG_SOFT_ALL, 32'ha);
        rdChk(CGL_REG_SOFT_ALL, 32'ha);
        wr(CGL_REG_SOFT_IDX, 32'h0);
        wr(CGL_REG_SOFT_LEVEL, 32'h1);
        rdChk(CGL_REG_SOFT_ALL, 32'hb);
        wr(CGL_REG_SOFT_IDX, 32'h3);
        wr(CGL_REG_SOFT_LEVEL, 32'h0);
        rdChk(CGL_REG_SOFT_ALL, 32'h3);
        wr(CGL_REG_LINE_SEL, 32'h1);
        wr(CGL_REG_SOURCE, {28'h0, CGL_SRC_SOFT0});
        cyc(3);
        chkPin(linePinOe, 4'h0);
        wr(CGL_REG_DIRECTION, 32'h1);
        cyc(3);
        chkPin(linePinOe, 4'h2);
        rdChk(CGL_REG_DIRECTION, 32'h1);
        rdChk(CGL_REG_LINE_SEL, 32'h1);
        rdChk(CGL_REG_SOFT_IDX, 32'h3);
        for (int p = 0; p < 2; p++) begin
            srcIn <= (p == 0) ? 4'h5 : 4'ha;
            for (int c = 0; c < 13; c++) begin
                if (c != 1) begin
                    e = (c < 4) ? extDrive[c] : (c < 8) ? 1'(4'h3 >> (c - 4)) : (c < 12) ? srcIn[c - 8] : 1'b0;
                    wr(CGL_REG_SOURCE, 32'(c));
                    cyc(3);
                    chkPin({3'h0, linePinOut[1]}, {3'h0, e});
                end
            end
        end
        rdChk(CGL_REG_SOURCE, 32'hc);
        wr(CGL_REG_SOURCE, {28'h0, CGL_SRC_SOFT0});
        wr(CGL_REG_INVERT, 32'h1);
        rdChk(CGL_REG_INVERT, 32'h1);
        cyc(3);
        chkPin({3'h0, linePinOut[1]}, 4'h0);
        wr(CGL_REG_INVERT, 32'h0);
        wr(CGL_REG_DIRECTION, 32'h0);
        cyc(3);
        chkPin(linePinOe, 4'h0);
    endtask : t_sources

    // Deglitch then debounce on line 2: glitch rejected, edge delayed
    task automatic t_deglitch();
        extDrive <= 4'h0;
        setFilter(2'h2, CGL_FLT_DEBOUNCE, 16'h2);
        setFilter(2'h2, CGL_FLT_DEGLITCH, 16'h2);
        rdChk(CGL_REG_FILTER_SPAN, 32'h2);
        cyc(10);
        extDrive <= 4'h4;
        cyc(50);
        extDrive <= 4'h0;
        cyc(400);
        rdChk(CGL_REG_LEVEL, 32'h0);
        extDrive <= 4'h4;
        cyc(100);
        rdChk(CGL_REG_LEVEL, 32'h0);
        cyc(300);
        rdChk(CGL_REG_LEVEL, 32'h1);
    endtask : t_deglitch

    // Debounce on line 3: first edge at once, then locked
    task automatic t_debounce();
        setFilter(2'h3, CGL_FLT_DEBOUNCE, 16'h2);
        rdChk(CGL_REG_FILTER_KIND, 32'h1);
        cyc(10);
        extDrive <= 4'hc;
        cyc(8);
        rdChk(CGL_REG_LEVEL, 32'h1);
        extDrive <= 4'h4;
        cyc(60);
        rdChk(CGL_REG_LEVEL, 32'h1);
        cyc(400);
        rdChk(CGL_REG_LEVEL, 32'h0);
    endtask : t_debounce

    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset_types();
        t_input_levels();
        t_sources();
        t_deglitch();
        t_debounce();
        print_verdict();
    end
endmodule : cgl_line_control_bench
